//--- ema_ctrl_pkg.sv
/*
 contents: constants for the extended modulo status control block: status word layout,
 register offsets, reset values and modifier decode encodings.
 assumes: compiled before every other file of the block.
*/
`default_nettype none
package ema_ctrl_pkg;
	localparam int unsigned STATUS_W = 24;
	localparam int unsigned LEGACY_W = 16;
	// register byte offsets
	localparam logic [11:0] OFF_STATUS = 12'h000;
	localparam logic [11:0] OFF_RESTORE = 12'h004;
	localparam logic [11:0] OFF_MODIFIER = 12'h008;
	localparam logic [11:0] OFF_DECODE = 12'h00C;
	localparam logic [11:0] OFF_ACTIVE = 12'h010;
	// status word field positions
	localparam int unsigned BIT_EMA = 18;
	localparam int unsigned BIT_SA = 17;
	localparam int unsigned BIT_FV = 16;
	localparam int unsigned BIT_LF = 15;
	localparam int unsigned BIT_SCALE_LO = 10;
	localparam int unsigned BIT_SCALE_HI = 11;
	localparam int unsigned BIT_RSV_LO = 12;
	localparam int unsigned BIT_RSV_HI = 14;
	// bits held by this block: 18..15 and 11..10
	localparam logic [23:0] STATUS_HELD_MASK = 24'h07_8C00;
	localparam logic [23:0] STATUS_RESET = 24'h00_0000;
	localparam logic [23:0] MODIFIER_RESET = 24'hFF_FFFF;
	// modifier patterns
	localparam logic [23:0] MOD_LINEAR_24 = 24'hFF_FFFF;
	localparam logic [23:0] MOD_REVERSE = 24'h00_0000;
	localparam logic [15:0] MOD_LINEAR_16 = 16'hFFFF;
	localparam int unsigned MWRAP_HI = 23;
	localparam int unsigned MWRAP_CLR = 22;
	localparam int unsigned MWRAP_LEGACY_HI = 15;
	localparam int unsigned MWRAP_LEGACY_CLR = 14;
	// stale instruction steps after a return-from-interrupt restore
	localparam logic [1:0] RTI_STALE_CYCLES = 2'h1;
	// modifier decode result
	typedef enum logic [2:0] {
		MODE_LINEAR,
		MODE_REVERSE,
		MODE_MODULO,
		MODE_MULTI_WRAP,
		MODE_RESERVED
	} addr_mode_e;
endpackage
`default_nettype wire

//--- modifier_decode.sv
/*
 contents: combinational decode of a modifier register value into an addressing mode.
 assumes: the enable input comes from the status word in use on the same clock.
*/
`default_nettype none
module modifier_decode
	import ema_ctrl_pkg::*;
(
	// control
	input wire logic ema_i,
	// modifier value
	input wire logic [23:0] modifier_i,
	// result
	output logic [2:0] mode_o,
	output logic [23:0] modulus_o
);
	// power-of-two test on modulus minus one
	function automatic logic all_ones_low(input logic [23:0] v);
		all_ones_low = ((v + 24'h00_0001) & v) == 24'h00_0000;
	endfunction

	wire logic [23:0] low22 = {2'b00, modifier_i[MWRAP_CLR-1:0]};
	wire logic [23:0] low14 = {10'h000, modifier_i[MWRAP_LEGACY_CLR-1:0]};
	wire logic [23:0] low15 = {9'h000, modifier_i[MWRAP_LEGACY_HI-1:0]};
	wire logic [23:0] low16 = {8'h00, modifier_i[LEGACY_W-1:0]};

	// extended range decode
	wire logic x_lin = modifier_i == MOD_LINEAR_24;
	wire logic x_rev = modifier_i == MOD_REVERSE;
	wire logic x_mod = !modifier_i[MWRAP_HI];
	wire logic x_wrap = modifier_i[MWRAP_HI] && !modifier_i[MWRAP_CLR]
		&& (low22 != 24'h00_0000) && all_ones_low(low22);

	// legacy 16-bit decode, upper bits ignored
	wire logic l_lin = modifier_i[LEGACY_W-1:0] == MOD_LINEAR_16;
	wire logic l_rev = modifier_i[LEGACY_W-1:0] == 16'h0000;
	wire logic l_mod = !modifier_i[MWRAP_LEGACY_HI];
	wire logic l_wrap = modifier_i[MWRAP_LEGACY_HI] && !modifier_i[MWRAP_LEGACY_CLR]
		&& (low14 != 24'h00_0000) && all_ones_low(low14);

	wire logic lin = ema_i ? x_lin : l_lin;
	wire logic rev = ema_i ? x_rev : l_rev;
	wire logic mdl = ema_i ? x_mod : l_mod;
	wire logic wrp = ema_i ? x_wrap : l_wrap;

	// priority: linear, reverse, multiple wrap, modulo
	assign mode_o = lin ? 3'(MODE_LINEAR) : rev ? 3'(MODE_REVERSE) : wrp ? 3'(MODE_MULTI_WRAP)
		: mdl ? 3'(MODE_MODULO) : 3'(MODE_RESERVED);
	// modulus for modulo and wrap modes, zero otherwise
	assign modulus_o = (lin || rev) ? 24'h00_0000
		: wrp ? (ema_i ? low22 : low14) + 24'h00_0001
		: mdl ? (ema_i ? modifier_i : low15) + 24'h00_0001
		: 24'h00_0000;
	wire logic unused_low16 = |low16;
endmodule
`default_nettype wire

//--- ema_status_ctrl.sv
/*
 contents: status word control for the address generation datapath, with the extended
 modulo enable, its stale window after a return-from-interrupt restore, and an APB slave.
 assumes: APB master on ref_clk_i; core events (restore, instruction step) are synchronous.
*/
// Added by the designer: the APB register port and the placing of the registers.
`default_nettype none
//
// Summary of operation
// - status bit 18 is the extended modulo enable, allowing modulo ranges up to 24 bits.
// - with the enable set, a modifier of all ones selects linear addressing.
// - with the enable set, a modifier of all zeros selects reverse-carry addressing.
// - with the enable set, modifier equal to modulus minus one selects modulo, moduli 2 to 2^23.
// - with the enable set, bit 23 set, bit 22 clear and low bits modulus minus one select wrap mode.
// - with the enable clear, the legacy 16-bit modulo range and decode apply.
// - after a restore that changes the enable, the next instruction still sees the old enable.
// - bits 17, 16, 15 and 11-10 hold arithmetic, forever loop, loop active and scaling, reset zero.
//
module ema_status_ctrl
	import ema_ctrl_pkg::*;
#(
	parameter int unsigned ADDR_W = 12
)
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core events
	input wire logic rti_restore_i,
	input wire logic [23:0] rti_status_i,
	input wire logic instr_step_i,
	// datapath view
	output logic ema_active_o,
	output logic [2:0] addr_mode_o,
	output logic [23:0] modulus_o,
	output logic [23:0] core_status_word_o
);
	generate
		if (ADDR_W < 5)
		begin : g_chk
			$error("ADDR_W too small for the register map");
		end
	endgenerate

	logic [23:0] core_status_word_r, core_status_word_nxt;
	logic [23:0] modifier_register_r, modifier_register_nxt;
	logic ema_seen_r, ema_seen_nxt;
	logic [1:0] stale_r, stale_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [2:0] mode_w;
	logic [23:0] modulus_w;

	// byte lane merge for writes
	function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] wd, input logic [3:0] st);
		merge = {st[2] ? wd[23:16] : old[23:16], st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction

	// address decode
	wire logic [11:0] addr12 = 12'(paddr);
	wire logic hit_status = addr12 == OFF_STATUS;
	wire logic hit_restore = addr12 == OFF_RESTORE;
	wire logic hit_modifier = addr12 == OFF_MODIFIER;
	wire logic hit_decode = addr12 == OFF_DECODE;
	wire logic hit_active = addr12 == OFF_ACTIVE;
	wire logic hit_any = hit_status || hit_restore || hit_modifier || hit_decode || hit_active;
	wire logic access = psel && penable;
	wire logic wr_ok = access && pwrite;
	wire logic ro_write = hit_decode || hit_active;

	// single-cycle access phase, error on unmapped address or write to read-only
	assign pready = 1'b1;
	assign pslverr = access && (!hit_any || (pwrite && ro_write));
	assign prdata = prdata_r;

	// status word writes: held bits only, reserved and foreign bits read zero
	wire logic [23:0] sw_status = merge(core_status_word_r, pwdata, pstrb) & STATUS_HELD_MASK;
	wire logic [23:0] rti_held = rti_status_i & STATUS_HELD_MASK;
	// a restore that flips the enable opens the stale window
	wire logic ema_flip = rti_restore_i && (rti_held[BIT_EMA] != core_status_word_r[BIT_EMA]);

	// next status word: restore has priority over a software write in the same cycle
	assign core_status_word_nxt = rti_restore_i ? rti_held
		: (wr_ok && hit_status) ? sw_status
		: core_status_word_r;

	// enable as seen by the datapath lags during the stale window
	assign stale_nxt = ema_flip ? RTI_STALE_CYCLES
		: (stale_r != 2'h0 && instr_step_i) ? stale_r - 2'h1
		: stale_r;
	assign ema_seen_nxt = (ema_flip || (stale_r != 2'h0 && !(instr_step_i && stale_r == 2'h1)))
		? ema_seen_r
		: core_status_word_nxt[BIT_EMA];
	assign ema_active_o = ema_seen_r;

	// modifier register, writable by software
	assign modifier_register_nxt = (wr_ok && hit_modifier) ? merge(modifier_register_r, pwdata, pstrb)
		: modifier_register_r;

	// read mux
	assign prdata_nxt = (psel && !penable && !pwrite) ?
		(hit_status ? {8'h00, core_status_word_r}
		: hit_restore ? {30'h0000_0000, stale_r}
		: hit_modifier ? {8'h00, modifier_register_r}
		: hit_decode ? {modulus_w[23:0], 5'h00, mode_w}
		: hit_active ? {31'h0000_0000, ema_seen_r}
		: 32'h0000_0000) : prdata_r;

	// decode modifier with the enable as currently seen
	modifier_decode u_dec (
		.ema_i(ema_seen_r),
		.modifier_i(modifier_register_r),
		.mode_o(mode_w),
		.modulus_o(modulus_w)
	);

	// output registers
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			addr_mode_o <= 3'(MODE_LINEAR);
			modulus_o <= 24'h00_0000;
		end
		else
		begin
			addr_mode_o <= mode_w;
			modulus_o <= modulus_w;
		end
	end

	// state registers, all clear on reset except the modifier register, which resets to all ones
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			core_status_word_r <= STATUS_RESET;
			ema_seen_r <= 1'b0;
			stale_r <= 2'h0;
			modifier_register_r <= MODIFIER_RESET;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			core_status_word_r <= core_status_word_nxt;
			ema_seen_r <= ema_seen_nxt;
			stale_r <= stale_nxt;
			modifier_register_r <= modifier_register_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign core_status_word_o = core_status_word_r;
endmodule
`default_nettype wire

//--- ema_status_ctrl_checker.sv
/* checker: port assertions for the status control block.
 assumes: bound to ema_status_ctrl, one clock, bench writes whole words. */
`default_nettype none
module ema_status_ctrl_checker #(parameter int unsigned ADDR_W = 12)
(
	// clock, reset and bus
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	// core events and datapath view
	input wire logic rti_restore_i,
	input wire logic [23:0] rti_status_i,
	input wire logic instr_step_i,
	input wire logic ema_active_o,
	input wire logic [2:0] addr_mode_o,
	input wire logic [23:0] core_status_word_o
);
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// whole-word writes in their access phase
	wire logic wr = psel && penable && pwrite && pstrb == 4'hF;
	wire logic st_wr = wr && paddr == 12'h000 && !rti_restore_i;
	wire logic md_wr = wr && paddr == 12'h008;
	chk_ema_reset: assert property ($rose(rst_b_i) |-> !ema_active_o)
		else $error("enable set after reset");
	chk_status_write: assert property (st_wr |=> core_status_word_o == (pwdata[23:0] & 24'h07_8C00))
		else $error("status word write wrong");
	chk_ema_follow: assert property (st_wr |-> ##[1:3] ema_active_o == pwdata[18])
		else $error("enable did not follow write");
	chk_mod_linear: assert property (md_wr && pwdata[23:0] == 24'hFF_FFFF |-> ##[1:3] addr_mode_o == 3'h0)
		else $error("linear mode missed");
	chk_mod_reverse: assert property (md_wr && pwdata[23:0] == 24'h00_0000 |-> ##[1:3] addr_mode_o == 3'h1)
		else $error("reverse mode missed");
	chk_legacy_modulo: assert property (
		md_wr && !ema_active_o && pwdata[23:14] == 10'h3FC && pwdata[13:0] != 14'h0 |-> ##[1:3] addr_mode_o == 3'h2)
		else $error("legacy modulo missed");
	chk_rti_stale: assert property (
		rti_restore_i && !instr_step_i && rti_status_i[18] != ema_active_o |=> $stable(ema_active_o))
		else $error("enable changed before instruction");
	chk_rti_catchup: assert property (
		instr_step_i && !rti_restore_i && ema_active_o != core_status_word_o[18]
		|-> ##[1:2] ema_active_o == core_status_word_o[18])
		else $error("enable stuck after instruction");
endmodule
bind ema_status_ctrl ema_status_ctrl_checker #(.ADDR_W(ADDR_W)) u_ema_status_ctrl_checker (.ref_clk_i(ref_clk_i),
	.rst_b_i(rst_b_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .rti_restore_i(rti_restore_i), .rti_status_i(rti_status_i), .instr_step_i(instr_step_i),
	.ema_active_o(ema_active_o), .addr_mode_o(addr_mode_o), .core_status_word_o(core_status_word_o));
`default_nettype wire

//--- ema_status_ctrl_tb_top.sv
/* testbench: corner and seeded random apb traffic plus restore events.
 assumes: package, design and checker compiled first. */
`default_nettype none
module ema_status_ctrl_tb_top import ema_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic rti_restore_i = 1'b0, instr_step_i = 1'b0, ema_active_o;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [23:0] rti_status_i = 24'h00_0000, modulus_o, core_status_word_o;
	logic [2:0] addr_mode_o;
	int miscompares = 0, samples_checked = 0, seed = 70;
	logic [23:0] corner [10] = '{24'hFF_FFFF, 24'h00_0000, 24'h00_0001, 24'h7F_FFFF, 24'h80_000F,
		24'h80_000E, 24'hFF_0003, 24'h00_FFFF, 24'h00_8007, 24'h00_C001};
	ema_status_ctrl u_ema_status_ctrl (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rti_restore_i(rti_restore_i), .rti_status_i(rti_status_i), .instr_step_i(instr_step_i),
		.ema_active_o(ema_active_o), .addr_mode_o(addr_mode_o), .modulus_o(modulus_o),
		.core_status_word_o(core_status_word_o));
	// clock
	initial
	begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// comparison and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one apb transfer, held until pready is seen
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do
		begin
			@(posedge ref_clk_i);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			miscompares++;
			stop_test();
		end
	endtask
	// expected decode word: modulus in 31:8, mode in 2:0
	function automatic logic [31:0] exp_dec(input logic ema, input logic [23:0] m);
		int h;
		logic [23:0] lo, w, mo;
		logic [2:0] md;
		h = ema ? 23 : 15;
		lo = ema ? m : {8'h00, m[15:0]};
		w = lo & ((24'h00_0001 << (h - 1)) - 24'h00_0001);
		mo = 24'h00_0000;
		md = 3'h4;
		if (lo == (ema ? 24'hFF_FFFF : 24'h00_FFFF))
			md = 3'h0;
		else if (lo == 24'h00_0000)
			md = 3'h1;
		else if (!lo[h])
		begin
			md = 3'h2;
			mo = lo + 24'h00_0001;
		end
		else if (!lo[h - 1] && w != 24'h00_0000 && ((w + 24'h00_0001) & w) == 24'h00_0000)
		begin
			md = 3'h3;
			mo = w + 24'h00_0001;
		end
		return {mo, 5'h00, md};
	endfunction
	task automatic run_decode(input logic ema);
		logic [23:0] m;
		logic [31:0] e;
		for (int i = 0; i < 40; i++)
		begin
			m = (i < 10) ? corner[i] : 24'($random(seed));
			e = exp_dec(ema, m);
			xfer(1'b1, OFF_MODIFIER, {8'h00, m});
			xfer(1'b0, OFF_DECODE, 32'h0000_0000);
			check(rd, e);
			check({29'h0, addr_mode_o}, {29'h0, e[2:0]});
			check({8'h00, modulus_o}, {8'h00, e[31:8]});
		end
	endtask
	// main sequence
	initial
	begin
		repeat (12) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		xfer(1'b0, OFF_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		xfer(1'b0, OFF_ACTIVE, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		run_decode(1'b0);
		xfer(1'b1, OFF_STATUS, 32'h00FF_FFFF);
		xfer(1'b0, OFF_STATUS, 32'h0000_0000);
		check(rd, 32'h0007_8C00);
		check({31'h0, ema_active_o}, 32'h0000_0001);
		run_decode(1'b1);
		xfer(1'b1, OFF_STATUS, 32'h0000_0000);
		repeat (3) @(posedge ref_clk_i);
		rti_restore_i <= 1'b1;
		rti_status_i <= 24'h04_0000;
		@(posedge ref_clk_i);
		rti_restore_i <= 1'b0;
		rti_status_i <= 24'hFB_FFFF;
		repeat (2) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		check({31'h0, ema_active_o}, 32'h0000_0000);
		check({8'h00, core_status_word_o}, 32'h0004_0000);
		xfer(1'b0, OFF_RESTORE, 32'h0000_0000);
		check(rd, 32'h0000_0001);
		@(posedge ref_clk_i);
		instr_step_i <= 1'b1;
		@(posedge ref_clk_i);
		instr_step_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		check({31'h0, ema_active_o}, 32'h0000_0001);
		// software clears the enable before the restore, so no stale window opens
		xfer(1'b1, OFF_STATUS, 32'h0000_0000);
		@(posedge ref_clk_i);
		rti_restore_i <= 1'b1;
		rti_status_i <= 24'h00_0000;
		@(posedge ref_clk_i);
		rti_restore_i <= 1'b0;
		@(negedge ref_clk_i);
		check({31'h0, ema_active_o}, 32'h0000_0000);
		xfer(1'b0, OFF_RESTORE, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		xfer(1'b0, 12'h040, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
		stop_test();
	end
endmodule
`default_nettype wire
